// >>> src/dtua_arbiter.v
// transfer unit bus cycle sequencer and arbiter
// Function
// - cpu bus cycles stall while unit owns bus
// - unit wins contention against cpu
// - request only at bus cycle ends
// - any state when cpu internal or asleep
// - peripheral irq or host strobe rising edge
// - ignore requests in reset and standby
// - master read on r/a, write on b
// - io transfer is dead, read, write
// - master read ram->port, write port->ram
// - dead cycle lasts exactly one state
// - dead cycle clears timer or adc flag
// - after dead cycle, read/write run only if flag still raised
// - serial flags clear on data access only
// - flag cleared in dead cycle cancels sequence
// - channel r master read highest priority
// - bound buffer: master read before write
// - io channels served a, b, c
// - no bus request one state after write
// - host cycles may interrupt io sequence
// - pending host holds io write
// - write only for channel that read
`timescale 1ns/1ps
`include "dtua_defines.vh"
module dtua_arbiter #(
   parameter FIFO_WIDTH = `DTUA_FIFO_WIDTH,
   parameter FIFO_DEPTH = `DTUA_FIFO_DEPTH,
   parameter FIFO_AW    = 3
)(
   // clock and reset
   input  wire                  ref_clk,
   input  wire                  rst_n,
   // cpu status
   input  wire                  cpu_bus_req,
   input  wire                  cpu_cycle_end,
   input  wire                  cpu_internal,
   input  wire                  cpu_sleep,
   input  wire                  cpu_standby,
   // modes
   input  wire                  bound_buffer_mode,
   input  wire                  query_mode,
   // host port strobes from pins, active low
   input  wire                  host_oe_n,
   input  wire                  host_we_n,
   input  wire                  host_query,
   // peripheral io requests, one per channel a/b/c
   input  wire [2:0]            io_req,
   input  wire [2:0]            io_src_sci,
   // host write data into the unit
   input  wire [FIFO_WIDTH-1:0] host_wdata,
   // ram read data during master read
   input  wire [FIFO_WIDTH-1:0] ram_rdata,
   // bus ownership
   output reg                   unit_bus_grant_r,
   output reg                   cpu_stall_r,
   output reg  [2:0]            cycle_kind_r,
   output reg  [1:0]            cycle_chan_r,
   // flag clears and data moves
   output reg  [2:0]            flag_clear_r,
   output reg                   port_load_r,
   output reg  [FIFO_WIDTH-1:0] port_data_r,
   output reg                   ram_write_r,
   output reg  [FIFO_WIDTH-1:0] ram_wdata_r,
   output reg                   host_wr_ready_r
);
   // ------------------------------------------------------------
   // host strobe synchronisers and edge detect
   // ------------------------------------------------------------
   reg [1:0] oe_sync_r;
   reg [1:0] we_sync_r;
   reg       oe_last_r;
   reg       we_last_r;
   wire      oe_rise;
   wire      we_rise;
   wire      active;

   // requests ignored while reset held or in standby
   assign active  = ~cpu_standby;
   assign oe_rise = oe_sync_r[1] & ~oe_last_r;
   assign we_rise = we_sync_r[1] & ~we_last_r;

   // two flops on the pins before any edge logic
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         oe_sync_r <= 2'b11;
         we_sync_r <= 2'b11;
         oe_last_r <= 1'b1;
         we_last_r <= 1'b1;
      end
      else
      begin
         oe_sync_r <= {oe_sync_r[0], host_oe_n};
         we_sync_r <= {we_sync_r[0], host_we_n};
         oe_last_r <= oe_sync_r[1];
         we_last_r <= we_sync_r[1];
      end
   end

   // ------------------------------------------------------------
   // pending host requests
   // ------------------------------------------------------------
   reg  pend_r_r;
   reg  pend_a_r;
   reg  pend_b_r;
   wire host_pend;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [FIFO_WIDTH-1:0] fifo_out_data;
   wire take_mrd_r;
   wire take_mrd_a;
   wire take_mwr_b;

   assign host_pend = pend_r_r | pend_a_r | (pend_b_r & fifo_out_valid);

   // master write data waits in the fifo; a full fifo stalls the host
   dtua_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (we_rise & active),
      .in_ready  (fifo_in_ready),
      .in_data   (host_wdata),
      .out_valid (fifo_out_valid),
      .out_ready (take_mwr_b),
      .out_data  (fifo_out_data)
   );

   // set wins over the clear taken in the same state
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_r_r <= 1'b0;
         pend_a_r <= 1'b0;
         pend_b_r <= 1'b0;
      end
      else
      begin
         if (oe_rise && active && query_mode && host_query)
            pend_r_r <= 1'b1;
         else if (take_mrd_r)
            pend_r_r <= 1'b0;
         if (oe_rise && active && !(query_mode && host_query))
            pend_a_r <= 1'b1;
         else if (take_mrd_a)
            pend_a_r <= 1'b0;
         if (we_rise && active)
            pend_b_r <= 1'b1;
         else if (take_mwr_b && !fifo_out_valid)
            pend_b_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // io request synchronisers
   // ------------------------------------------------------------
   reg  [2:0] io_sync1_r;

   // flags come from on-chip logic on this clock, so one gating flop
   // is enough; a deeper chain would keep a flag that the dead cycle
   // already cleared alive long enough to start a second, bogus dead
   // cycle after the gap
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         io_sync1_r <= 3'b000;
      else
         io_sync1_r <= io_req & {3{active}};
   end

   // ------------------------------------------------------------
   // arbitration and cycle sequencing
   // ------------------------------------------------------------
   reg  [2:0] kind_nxt;
   reg  [1:0] chan_nxt;
   reg        wr_pend_r;       // io write held for a channel
   reg  [1:0] wr_chan_r;
   reg        gap_r;
   wire       boundary;
   wire       may_req;

   // request only at cycle boundaries unless cpu not using bus
   // the end of any unit cycle is a boundary as well
   assign boundary = cpu_cycle_end | cpu_internal | cpu_sleep | ~cpu_bus_req |
                     unit_bus_grant_r;
   assign may_req  = boundary & ~gap_r & active;

   assign take_mrd_r = (kind_nxt == `DTUA_CYC_MRD_R);
   assign take_mrd_a = (kind_nxt == `DTUA_CYC_MRD_A);
   assign take_mwr_b = (kind_nxt == `DTUA_CYC_MWR_B);

   // priority picker, evaluated once per state
   always @*
   begin
      kind_nxt = `DTUA_CYC_IDLE;
      chan_nxt = `DTUA_CH_A;
      if (cycle_kind_r == `DTUA_CYC_DEAD)
      begin
         // confirm request still raised, else cancel read and write
         // live flag: a cpu clear inside the dead state must cancel now
         if (io_req[cycle_chan_r] && active)
         begin
            kind_nxt = `DTUA_CYC_READ;
            chan_nxt = cycle_chan_r;
         end
      end
      else if (cycle_kind_r == `DTUA_CYC_WRITE || cycle_kind_r == `DTUA_CYC_MWR_B ||
               cycle_kind_r == `DTUA_CYC_GAP)
      begin
         if (cycle_kind_r != `DTUA_CYC_GAP)
            kind_nxt = `DTUA_CYC_GAP;
      end
      else if (may_req)
      begin
         if (pend_r_r)
         begin
            kind_nxt = `DTUA_CYC_MRD_R;
            chan_nxt = `DTUA_CH_R;
         end
         else if (pend_a_r && (bound_buffer_mode || !(pend_b_r && fifo_out_valid)))
         begin
            kind_nxt = `DTUA_CYC_MRD_A;
            chan_nxt = `DTUA_CH_A;
         end
         else if (pend_b_r && fifo_out_valid)
         begin
            kind_nxt = `DTUA_CYC_MWR_B;
            chan_nxt = `DTUA_CH_B;
         end
         else if (pend_a_r)
         begin
            kind_nxt = `DTUA_CYC_MRD_A;
            chan_nxt = `DTUA_CH_A;
         end
         else if (wr_pend_r)
         begin
            kind_nxt = `DTUA_CYC_WRITE;
            chan_nxt = wr_chan_r;
         end
         else if (io_sync1_r[0])
            kind_nxt = `DTUA_CYC_DEAD;
         else if (io_sync1_r[1])
         begin
            kind_nxt = `DTUA_CYC_DEAD;
            chan_nxt = `DTUA_CH_B;
         end
         else if (io_sync1_r[2])
         begin
            kind_nxt = `DTUA_CYC_DEAD;
            chan_nxt = `DTUA_CH_C;
         end
      end
   end

   // registered grant: one owner per state
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cycle_kind_r     <= `DTUA_CYC_IDLE;
         cycle_chan_r     <= `DTUA_CH_A;
         unit_bus_grant_r <= 1'b0;
         cpu_stall_r      <= 1'b0;
         gap_r            <= 1'b0;
         wr_pend_r        <= 1'b0;
         wr_chan_r        <= `DTUA_CH_A;
      end
      else
      begin
         cycle_kind_r <= kind_nxt;
         cycle_chan_r <= chan_nxt;
         // unit beats cpu; cpu internal work still runs
         unit_bus_grant_r <= (kind_nxt != `DTUA_CYC_IDLE) &&
                             (kind_nxt != `DTUA_CYC_GAP);
         cpu_stall_r <= (kind_nxt != `DTUA_CYC_IDLE) &&
                        (kind_nxt != `DTUA_CYC_GAP) && cpu_bus_req;
         gap_r <= (kind_nxt == `DTUA_CYC_GAP);
         // once the read cycle runs the write is owed regardless of flag
         if (kind_nxt == `DTUA_CYC_READ)
         begin
            wr_pend_r <= 1'b1;
            wr_chan_r <= chan_nxt;
         end
         else if (kind_nxt == `DTUA_CYC_WRITE)
            wr_pend_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // flag clears and data moves
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_clear_r    <= 3'b000;
         port_load_r     <= 1'b0;
         port_data_r     <= {FIFO_WIDTH{1'b0}};
         ram_write_r     <= 1'b0;
         ram_wdata_r     <= {FIFO_WIDTH{1'b0}};
         host_wr_ready_r <= 1'b0;
      end
      else
      begin
         flag_clear_r <= 3'b000;
         // timer and adc flags clear in dead cycle; serial flags don't
         if (cycle_kind_r == `DTUA_CYC_DEAD && !io_src_sci[cycle_chan_r])
            flag_clear_r[cycle_chan_r] <= 1'b1;
         port_load_r <= take_mrd_r | take_mrd_a;
         if (take_mrd_r || take_mrd_a)
            port_data_r <= ram_rdata;
         ram_write_r <= take_mwr_b;
         if (take_mwr_b)
            ram_wdata_r <= fifo_out_data;
         host_wr_ready_r <= fifo_in_ready;
      end
   end
endmodule // dtua_arbiter

// >>> src/dtua_defines.vh
// constants for the transfer unit bus cycle arbiter
`ifndef DTUA_DEFINES_VH
`define DTUA_DEFINES_VH
// bus cycle kinds shown on cycle_kind_r
`define DTUA_CYC_IDLE     3'h0
`define DTUA_CYC_MRD_R    3'h1
`define DTUA_CYC_MRD_A    3'h2
`define DTUA_CYC_MWR_B    3'h3
`define DTUA_CYC_DEAD     3'h4
`define DTUA_CYC_READ     3'h5
`define DTUA_CYC_WRITE    3'h6
`define DTUA_CYC_GAP      3'h7
// channel codes
`define DTUA_CH_A         2'h0
`define DTUA_CH_B         2'h1
`define DTUA_CH_C         2'h2
`define DTUA_CH_R         2'h3
// dead cycle and post-write gap, in states
`define DTUA_DEAD_STATES  1
`define DTUA_GAP_STATES   1
// fifo defaults
`define DTUA_FIFO_WIDTH   8
`define DTUA_FIFO_DEPTH   8
`endif

// >>> src/dtua_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module dtua_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
)(
   // clock and reset
   input  wire             ref_clk,
   input  wire             rst_n,
   // fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wptr_r;
   reg [AW-1:0]    rptr_r;
   reg [AW:0]      count_r;
   wire            push;
   wire            pop;

   // full and empty come straight from the count
   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage array, no reset needed
   always @(posedge ref_clk)
   begin
      if (push)
         mem_r[wptr_r] <= in_data;
   end

   // pointers and count
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wptr_r  <= {AW{1'b0}};
         rptr_r  <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wptr_r <= (wptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_r + 1'b1;
         if (pop)
            rptr_r <= (rptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_r + 1'b1;
         if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end
endmodule // dtua_fifo

// >>> verification/dtua_arbiter_sva.sv
// port checker for the bus cycle arbiter
`timescale 1ns/1ps
`include "dtua_defines.vh"
module dtua_arbiter_chk (
   // clock and reset
   input wire       ref_clk,
   input wire       rst_n,
   // watched ports
   input wire       cpu_standby,
   input wire       unit_bus_grant_r,
   input wire       cpu_stall_r,
   input wire [2:0] cycle_kind_r,
   input wire [1:0] cycle_chan_r,
   input wire [2:0] flag_clear_r,
   input wire       ram_write_r
);
   reg [1:0] rd_chan_r;
   // channel of the last read, so a write can be paired with it
   always @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         rd_chan_r <= 2'h0;
      else if (cycle_kind_r == `DTUA_CYC_READ)
         rd_chan_r <= cycle_chan_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   dead_next_a: assert property (
      cycle_kind_r == `DTUA_CYC_DEAD |=>
      cycle_kind_r == `DTUA_CYC_READ || cycle_kind_r == `DTUA_CYC_IDLE)
      else $error("dead cycle not followed by read or idle");
   read_next_a: assert property (
      cycle_kind_r == `DTUA_CYC_READ |=> cycle_kind_r inside
      {`DTUA_CYC_WRITE, `DTUA_CYC_MRD_R, `DTUA_CYC_MRD_A, `DTUA_CYC_MWR_B})
      else $error("read cycle followed by a wrong cycle");
   write_gap_a: assert property (
      cycle_kind_r == `DTUA_CYC_WRITE || cycle_kind_r == `DTUA_CYC_MWR_B |=>
      cycle_kind_r == `DTUA_CYC_GAP)
      else $error("no quiet state after a write");
   write_chan_a: assert property (
      cycle_kind_r == `DTUA_CYC_WRITE |-> cycle_chan_r == rd_chan_r)
      else $error("write on a channel that did not read");
   clear_dead_a: assert property (
      flag_clear_r != 3'h0 |-> $past(cycle_kind_r) == `DTUA_CYC_DEAD &&
      flag_clear_r == (3'h1 << $past(cycle_chan_r)))
      else $error("flag clear outside its dead cycle");
   stall_grant_a: assert property (
      cpu_stall_r |-> unit_bus_grant_r)
      else $error("cpu stalled without unit owning bus");
   busy_grant_a: assert property (
      cycle_kind_r != `DTUA_CYC_IDLE && cycle_kind_r != `DTUA_CYC_GAP |->
      unit_bus_grant_r)
      else $error("unit cycle without bus grant");
   ram_write_a: assert property (
      ram_write_r |-> cycle_kind_r == `DTUA_CYC_MWR_B ||
      $past(cycle_kind_r) == `DTUA_CYC_MWR_B)
      else $error("ram write outside master write");
   standby_idle_a: assert property (
      (cpu_standby && cycle_kind_r == `DTUA_CYC_IDLE) [*6] |=>
      cycle_kind_r == `DTUA_CYC_IDLE)
      else $error("cycle started in standby");
endmodule // dtua_arbiter_chk
bind dtua_arbiter dtua_arbiter_chk dtua_arbiter_chk_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .cpu_standby(cpu_standby),
   .unit_bus_grant_r(unit_bus_grant_r), .cpu_stall_r(cpu_stall_r),
   .cycle_kind_r(cycle_kind_r), .cycle_chan_r(cycle_chan_r),
   .flag_clear_r(flag_clear_r), .ram_write_r(ram_write_r));

// >>> verification/dtua_far_model.sv
// peripheral flags, host master strobes and ram data
`timescale 1ns/1ps
module dtua_far_model #(
   parameter RAM_BYTE = 8'h5a
)(
   // clock and reset
   input wire       ref_clk,
   input wire       rst_n,
   // peripheral flags
   input wire [2:0] flag_set,
   input wire [2:0] flag_drop,
   input wire [2:0] flag_clear_r,
   output reg [2:0] io_req,
   // host master
   input wire       rd_go,
   input wire       wr_go,
   output wire      host_oe_n,
   output wire      host_we_n,
   output wire [7:0] ram_rdata
);
   reg [1:0] oe_cnt_r;
   reg [1:0] we_cnt_r;
   assign host_oe_n = (oe_cnt_r == 2'h0); // strobe ends with a rise
   assign host_we_n = (we_cnt_r == 2'h0);
   assign ram_rdata = RAM_BYTE;
   // flags stay up until the unit or the cpu clears them
   always @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
      begin
         io_req   <= 3'h0;
         oe_cnt_r <= 2'h0;
         we_cnt_r <= 2'h0;
      end
      else
      begin
         io_req   <= #1 (io_req | flag_set) & ~flag_drop & ~flag_clear_r;
         oe_cnt_r <= #1 rd_go ? 2'h2 : oe_cnt_r - (oe_cnt_r != 2'h0);
         we_cnt_r <= #1 wr_go ? 2'h2 : we_cnt_r - (we_cnt_r != 2'h0);
      end
endmodule // dtua_far_model

// >>> verification/dtua_arbiter_bench.sv
// self-checking bench for the bus cycle arbiter
`timescale 1ns/1ps
`include "dtua_defines.vh"
module dtua_arbiter_bench;
   reg        ref_clk = 1'b0, rst_n = 1'b0, cpu_bus_req = 1'b0, cpu_cycle_end = 1'b0;
   reg        cpu_internal = 1'b1, cpu_standby = 1'b0, bound_buffer_mode = 1'b0;
   reg        query_mode = 1'b0, host_query = 1'b0, rd_go = 1'b0, wr_go = 1'b0;
   reg  [2:0] flag_set = 3'h0, flag_drop = 3'h0;
   reg  [5:0] seq;
   wire [2:0] io_req, cycle_kind_r, flag_clear_r;
   wire [1:0] cycle_chan_r;
   wire [7:0] ram_rdata, port_data_r, ram_wdata_r;
   wire       host_oe_n, host_we_n, unit_bus_grant_r, cpu_stall_r;
   wire       port_load_r, ram_write_r, host_wr_ready_r;
   integer    fail_count = 0, check_count = 0, n, cnt, t_rd, t_mr, t_wr;
   always #4 ref_clk = ~ref_clk;
   dtua_arbiter dtua_arbiter_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .cpu_bus_req(cpu_bus_req), .cpu_cycle_end(cpu_cycle_end), .cpu_internal(cpu_internal),
      .cpu_sleep(1'b0), .cpu_standby(cpu_standby), .bound_buffer_mode(bound_buffer_mode),
      .query_mode(query_mode), .host_oe_n(host_oe_n), .host_we_n(host_we_n),
      .host_query(host_query), .io_req(io_req), .io_src_sci(3'h0), .host_wdata(8'hc3),
      .ram_rdata(ram_rdata), .unit_bus_grant_r(unit_bus_grant_r), .cpu_stall_r(cpu_stall_r),
      .cycle_kind_r(cycle_kind_r), .cycle_chan_r(cycle_chan_r), .flag_clear_r(flag_clear_r),
      .port_load_r(port_load_r), .port_data_r(port_data_r), .ram_write_r(ram_write_r),
      .ram_wdata_r(ram_wdata_r), .host_wr_ready_r(host_wr_ready_r));
   dtua_far_model dtua_far_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .flag_set(flag_set), .flag_drop(flag_drop), .flag_clear_r(flag_clear_r),
      .io_req(io_req), .rd_go(rd_go), .wr_go(wr_go), .host_oe_n(host_oe_n),
      .host_we_n(host_we_n), .ram_rdata(ram_rdata));
   task check(input [8*12:1] what, input [7:0] seen, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp)
         begin
            fail_count = fail_count + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task ck_kind(input [2:0] k);
      check("cycle kind", {5'h0, cycle_kind_r}, {5'h0, k});
   endtask
   task tick;
      begin
         @(posedge ref_clk);
         #1;
      end
   endtask
   // one strobe per source, dropped after a single edge
   task fire(input [2:0] f, input r, input w);
      begin
         flag_set = f;
         rd_go = r;
         wr_go = w;
         tick;
         flag_set = 3'h0;
         rd_go = 1'b0;
         wr_go = 1'b0;
      end
   endtask
   // bounded wait; k of 0 means any cycle other than idle
   task wait_kind(input [2:0] k);
      begin
         n = 0;
         while ((k == 3'h0 ? cycle_kind_r === 3'h0 : cycle_kind_r !== k) && n < 40)
         begin
            tick;
            n = n + 1;
         end
         check("kind reached", {7'h0, n < 40}, 8'h1);
      end
   endtask
   // counts cycles of kind k over a span, sampled each state
   task count_kind(input [2:0] k, input integer span);
      begin
         cnt = 0;
         repeat (span)
         begin
            cnt = cnt + (cycle_kind_r === k);
            tick;
         end
      end
   endtask
   task s_io;
      begin
         cpu_internal = 1'b0;
         cpu_bus_req = 1'b1;
         cpu_cycle_end = 1'b1;
         fire(3'h1, 1'b0, 1'b0);
         wait_kind(`DTUA_CYC_DEAD);
         check("dead chan", {6'h0, cycle_chan_r}, 8'h0);
         tick;
         ck_kind(`DTUA_CYC_READ);
         check("flag clear", {5'h0, flag_clear_r}, 8'h1);
         check("cpu stall", {7'h0, cpu_stall_r}, 8'h1);
         tick;
         ck_kind(`DTUA_CYC_WRITE);
         tick;
         ck_kind(`DTUA_CYC_GAP);
         cpu_internal = 1'b1;
         cpu_bus_req = 1'b0;
         cpu_cycle_end = 1'b0;
         fire(3'h1, 1'b0, 1'b0);
         flag_drop = 3'h1;
         tick;
         flag_drop = 3'h0;
         wait_kind(`DTUA_CYC_DEAD);
         tick;
         ck_kind(`DTUA_CYC_IDLE);
      end
   endtask
   task s_order;
      begin
         seq = 6'h0;
         fire(3'h7, 1'b0, 1'b0);
         for (n = 0; n < 40; n = n + 1)
         begin
            if (cycle_kind_r === `DTUA_CYC_DEAD)
               seq = {seq[3:0], cycle_chan_r};
            tick;
         end
         check("dead order", {2'h0, seq}, 8'h06);
      end
   endtask
   task s_host;
      begin
         query_mode = 1'b1;
         host_query = 1'b1;
         bound_buffer_mode = 1'b1;
         fire(3'h0, 1'b1, 1'b1);
         wait_kind(3'h0);
         ck_kind(`DTUA_CYC_MRD_R);
         check("mrd chan", {6'h0, cycle_chan_r}, 8'h3);
         if (port_load_r !== 1'b1)
            tick;
         check("port data", port_data_r, 8'h5a);
         wait_kind(`DTUA_CYC_MWR_B);
         check("mwr chan", {6'h0, cycle_chan_r}, 8'h1);
         if (ram_write_r !== 1'b1)
            tick;
         check("ram data", ram_wdata_r, 8'hc3);
         count_kind(`DTUA_CYC_WRITE, 20);
         check("no io write", cnt[7:0], 8'h0);
         query_mode = 1'b0;
         host_query = 1'b0;
         fire(3'h0, 1'b1, 1'b1);
         wait_kind(3'h0);
         ck_kind(`DTUA_CYC_MRD_A);
         count_kind(`DTUA_CYC_MWR_B, 20);
         check("mwr count", cnt[7:0], 8'h1);
         // host strobe first, io flag later, so the read lands first
         fire(3'h0, 1'b1, 1'b0);
         tick;
         tick;
         fire(3'h2, 1'b0, 1'b0);
         t_rd = 0;
         t_mr = 0;
         t_wr = 0;
         for (n = 1; n < 40; n = n + 1)
         begin
            if (cycle_kind_r === `DTUA_CYC_READ)
               t_rd = n;
            if (cycle_kind_r === `DTUA_CYC_MRD_A)
               t_mr = n;
            if (cycle_kind_r === `DTUA_CYC_WRITE)
               t_wr = n;
            tick;
         end
         check("host insert", {7'h0, t_rd < t_mr && t_mr < t_wr}, 8'h1);
      end
   endtask
   // bus held by the cpu so the write queue fills, then drains
   task s_fill;
      begin
         cpu_internal = 1'b0;
         cpu_bus_req = 1'b1;
         cpu_standby = 1'b1;
         fire(3'h1, 1'b1, 1'b0);
         count_kind(`DTUA_CYC_IDLE, 12);
         check("standby idle", cnt[7:0], 8'd12);
         flag_drop = 3'h1;
         tick;
         flag_drop = 3'h0;
         cpu_standby = 1'b0;
         // two spare edges so each strobe ends with a rise
         for (n = 0; n < 9; n = n + 1)
         begin
            fire(3'h0, 1'b0, 1'b1);
            tick;
            tick;
         end
         tick;
         tick;
         count_kind(`DTUA_CYC_IDLE, 20);
         check("idle held", cnt[7:0], 8'd20);
         check("fifo full", {7'h0, host_wr_ready_r}, 8'h0);
         cpu_internal = 1'b1;
         cpu_bus_req = 1'b0;
         count_kind(`DTUA_CYC_MWR_B, 80);
         check("drained", cnt[7:0], 8'h8);
         check("fifo free", {7'h0, host_wr_ready_r}, 8'h1);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #200000;
      fail_count = fail_count + 1;
      wrap_up;
   end
   initial
   begin
      repeat (4) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      ck_kind(`DTUA_CYC_IDLE);
      check("grant reset", {7'h0, unit_bus_grant_r}, 8'h0);
      s_io;
      s_order;
      s_host;
      s_fill;
      wrap_up;
   end
endmodule // dtua_arbiter_bench
